//--- rtl/low_voltage_detect_ctrl.v
// low-voltage detect control register, flag and wake logic with an axi4-lite slave
`timescale 1ns/1ps
`include "lvd_ctrl_defines.vh"
module low_voltage_detect_ctrl (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire comparator_low,
  input wire ref_settled,
  input wire ref_shared_on,
  input wire sleep_mode,
  input wire global_irq_enable,
  output reg detect_power_enable,
  output reg [3:0] trip_level_select,
  output reg use_external_trip_input,
  output reg [13:0] tap_select,
  output reg low_voltage_flag,
  output reg low_voltage_irq_enable,
  output wire irq_request,
  output wire wake_request,
  output wire vector_on_wake
);

  // write channel holding registers; address and data may come in either order
  reg aw_held;
  reg [3:0] aw_addr;
  reg w_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  // both stages of each synchroniser; the first is read only by the second
  reg comp_meta;
  reg comp_sync;
  reg settled_meta;
  reg settled_sync;
  // status and next-state values
  reg ref_stable_flag;
  reg next_flag;
  reg next_power_enable;
  reg [3:0] next_level;
  reg next_irq_enable;
  reg [13:0] next_tap;
  reg [31:0] next_rdata;
  reg [1:0] next_rresp;
  reg [1:0] next_bresp;
  wire aw_take;
  wire w_take;
  wire do_write;
  wire do_read;
  wire ctrl_write;
  wire flag_write;
  wire flag_clear;
  wire ref_ok;
  wire flag_trip;

  // a channel is taken at the edge where its valid and ready are both high
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;

  // each ready only while its own channel holds nothing and no response is pending
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;

  // word index match; the two low address bits are ignored
  function addr_match;
    input [3:0] addr;
    input [3:0] target;
    begin
      addr_match = addr[3:2] == target[3:2];
    end
  endfunction

  // an 8-bit register is touched only through byte lane 0
  function lane0_hit;
    input [3:0] addr;
    input [3:0] strb;
    input [3:0] target;
    begin
      lane0_hit = addr_match(addr, target) && strb[0];
    end
  endfunction

  // any address outside the two registers answers with an error
  function addr_mapped;
    input [3:0] addr;
    begin
      addr_mapped = addr_match(addr, `LVD_CONTROL_ADDR) || addr_match(addr, `LVD_FLAG_ADDR);
    end
  endfunction

  // one-hot tap, bit n-1 for code n; reserved and external codes pick no tap
  function [13:0] tap_decode;
    input [3:0] level;
    begin
      case (level)
        4'h1: tap_decode = 14'h0001;
        4'h2: tap_decode = 14'h0002;
        4'h3: tap_decode = 14'h0004;
        4'h4: tap_decode = 14'h0008;
        4'h5: tap_decode = 14'h0010;
        4'h6: tap_decode = 14'h0020;
        4'h7: tap_decode = 14'h0040;
        4'h8: tap_decode = 14'h0080;
        4'h9: tap_decode = 14'h0100;
        4'hA: tap_decode = 14'h0200;
        4'hB: tap_decode = 14'h0400;
        4'hC: tap_decode = 14'h0800;
        4'hD: tap_decode = 14'h1000;
        4'hE: tap_decode = 14'h2000;
        default: tap_decode = 14'h0000;
      endcase
    end
  endfunction

  // control word as software sees it; bits 7 and 6 are not implemented
  function [31:0] ctrl_word;
    input stable;
    input enable;
    input [3:0] level;
    begin
      ctrl_word = {26'h0000000, stable, enable, level}; // see R1, see R2
    end
  endfunction

  // flag word: interrupt enable sits above the flag
  function [31:0] flag_word;
    input irq_enable;
    input flag;
    begin
      flag_word = {30'h00000000, irq_enable, flag};
    end
  endfunction

  // write address capture
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'h0;
      aw_addr <= 4'h0;
    end else if (aw_take) begin
      aw_held <= 1'h1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'h0;
    end
  end

  // write data capture
  always @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'h0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (w_take) begin
      w_held <= 1'h1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'h0;
    end
  end

  // response code; a write without byte lane 0 changes nothing yet answers okay
  always @* begin
    if (addr_mapped(aw_addr)) begin
      next_bresp = `AXI_RESP_OKAY;
    end else begin
      next_bresp = `AXI_RESP_SLVERR;
    end
  end

  // response stands until bready is sampled high
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'h0;
      s_axi_bresp <= `AXI_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'h1;
      s_axi_bresp <= next_bresp;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'h0;
    end
  end

  // register strobes for the two words
  assign ctrl_write = do_write && lane0_hit(aw_addr, w_strb, `LVD_CONTROL_ADDR);
  assign flag_write = do_write && lane0_hit(aw_addr, w_strb, `LVD_FLAG_ADDR);
  assign flag_clear = flag_write && !w_data[`LVD_FLAG_BIT];

  // control register write; the stable bit is read-only and has no store here
  always @* begin
    next_power_enable = detect_power_enable;
    next_level = trip_level_select;
    if (ctrl_write) begin
      next_power_enable = w_data[`LVD_ENABLE_BIT]; // see R4
      next_level = w_data[`LVD_LEVEL_MSB:`LVD_LEVEL_LSB];
    end
  end

  // control fields take their reset state on any reset, detector off
  always @(posedge aclk) begin
    if (!aresetn) begin
      detect_power_enable <= 1'h0; // see R7
      trip_level_select <= `LVD_LEVEL_RESET; // see R7
    end else begin
      detect_power_enable <= next_power_enable;
      trip_level_select <= next_level;
    end
  end

  // interrupt enable lives beside the flag in the second word
  always @* begin
    next_irq_enable = low_voltage_irq_enable;
    if (flag_write) begin
      next_irq_enable = w_data[`LVD_IRQ_EN_BIT];
    end
  end

  // interrupt enable register
  always @(posedge aclk) begin
    if (!aresetn) begin
      low_voltage_irq_enable <= 1'h0;
    end else begin
      low_voltage_irq_enable <= next_irq_enable;
    end
  end

  // tap decode from the selected level
  always @* begin
    next_tap = tap_decode(trip_level_select); // see R6
  end

  // steering is registered so the analog mux never sees a decode glitch
  always @(posedge aclk) begin
    if (!aresetn) begin
      use_external_trip_input <= 1'h0;
      tap_select <= 14'h0000;
    end else begin
      use_external_trip_input <= trip_level_select == `LVD_LEVEL_EXTERNAL; // see R5
      tap_select <= next_tap; // see R6
    end
  end

  // two-stage synchronisers; first stage feeds only the second
  always @(posedge aclk) begin
    if (!aresetn) begin
      comp_meta <= 1'h0;
      comp_sync <= 1'h0;
      settled_meta <= 1'h0;
      settled_sync <= 1'h0;
    end else begin
      comp_meta <= comparator_low; // see R19
      comp_sync <= comp_meta;
      settled_meta <= ref_settled; // see R19
      settled_sync <= settled_meta;
    end
  end

  // settling is timed on the analog side, so a clock change cannot shorten it;
  // a reference already kept running by the shared circuit needs no wait
  assign ref_ok = ref_shared_on || settled_sync; // see R11, see R12

  // stable flag drops one clock after the detector is powered down
  always @(posedge aclk) begin
    if (!aresetn) begin
      ref_stable_flag <= 1'h0; // see R7
    end else begin
      ref_stable_flag <= detect_power_enable && ref_ok; // see R2
    end
  end

  // trips count only once the reference has settled;
  // a comparator pulse shorter than a clock may be missed by the synchroniser
  assign flag_trip = ref_stable_flag && comp_sync; // see R9, see R17

  // sticky flag; a trip in the clearing cycle wins over the clear
  always @* begin
    next_flag = low_voltage_flag;
    if (flag_clear) begin
      next_flag = 1'h0; // see R20
    end
    // sleep does not gate this path, so trips still land while asleep
    if (flag_trip) begin
      next_flag = 1'h1; // see R13
    end
  end

  // flag register
  always @(posedge aclk) begin
    if (!aresetn) begin
      low_voltage_flag <= 1'h0;
    end else begin
      low_voltage_flag <= next_flag;
    end
  end

  // the core owns sleep and vectoring; these only tell it what to do
  assign irq_request = low_voltage_flag && low_voltage_irq_enable; // see R18
  assign wake_request = sleep_mode && irq_request; // see R14
  assign vector_on_wake = wake_request && global_irq_enable; // see R15

  // read data for the addressed word; unmapped words read zero with an error
  always @* begin
    next_rdata = 32'h00000000;
    next_rresp = `AXI_RESP_OKAY;
    if (addr_match(s_axi_araddr, `LVD_CONTROL_ADDR)) begin
      next_rdata = ctrl_word(ref_stable_flag, detect_power_enable, trip_level_select);
    end else if (addr_match(s_axi_araddr, `LVD_FLAG_ADDR)) begin
      next_rdata = flag_word(low_voltage_irq_enable, low_voltage_flag);
    end else begin
      next_rresp = `AXI_RESP_SLVERR;
    end
  end

  // read response stands until rready is sampled high
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'h0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `AXI_RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'h1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'h0;
    end
  end

endmodule // low_voltage_detect_ctrl

//--- rtl/lvd_ctrl_defines.vh
// constants for the low-voltage detect control block
// Behaviour
// R1 - bits 7 and 6 of the control register always read zero
// R2 - bit 5 reads one only when flagging at the selected level works
// R3 - software keeps the interrupt off while the stable flag is zero
// R4 - bit 4 powers the detector up when one, down when zero
// R5 - selector all ones routes the external trip input to the comparator
// R6 - codes 1 to 14 pick ascending internal taps; code 0 is reserved
// R7 - any reset clears stable and enable, sets selector to 0101
// R8 - software: level, irq off, enable, poll stable, clear flag, irq on
// R9 - no flag from the comparator until the reference has settled
// R10 - software clears the flag after settling, it may be spurious
// R11 - settling time is fixed, not counted in system clock cycles
// R12 - settling wait applies only when no sharing circuit keeps reference up
// R13 - when enabled the detector keeps working in sleep
// R14 - a trip in sleep sets the flag and requests wake-up; wake_request here also needs the interrupt enable set
// R15 - after wake, vector only if global interrupts enabled, else continue
// R16 - software enables the detector only for short check periods
// R17 - flag sets when the selected supply tap falls below the reference
// R18 - flag set with its interrupt enabled makes the core take the vector
// R19 - comparator and settled inputs pass two synchroniser flip-flops
// R20 - flag stays set until software clears it
`ifndef LVD_CTRL_DEFINES_VH
`define LVD_CTRL_DEFINES_VH
`define LVD_CONTROL_ADDR 4'h0
`define LVD_FLAG_ADDR 4'h4
`define LVD_STABLE_BIT 5
`define LVD_ENABLE_BIT 4
`define LVD_FLAG_BIT 0
`define LVD_IRQ_EN_BIT 1
`define LVD_LEVEL_MSB 3
`define LVD_LEVEL_LSB 0
`define LVD_LEVEL_RESET 4'h5
`define LVD_LEVEL_EXTERNAL 4'hF
`define LVD_LEVEL_RESERVED 4'h0
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2
`endif

//--- sim/lvd_front_end.sv
// analog front end model: divider taps, comparator, reference settling
`timescale 1ns/1ps
module lvd_front_end (
  input wire aclk,
  input wire detect_power_enable,
  input wire use_external_trip_input,
  input wire [13:0] tap_select,
  input wire [3:0] supply,
  input wire ext_low,
  input wire ref_shared_on,
  output wire comparator_low,
  output wire ref_settled
);
  int cnt = 0;
  // settling takes 20 aclk cycles in this model, restarted by every power-down
  always @(posedge aclk) cnt <= detect_power_enable ? cnt + (cnt < 20) : 0;
  assign ref_settled = cnt >= 20;
  // unsettled reference trips falsely, as the real one may
  // a reference kept running by the shared circuit never trips falsely
  assign comparator_low = detect_power_enable && (!(ref_settled || ref_shared_on) ||
    (use_external_trip_input ? ext_low : |(tap_select >> supply)));
endmodule // lvd_front_end

//--- sim/lvd_assertions.sv
// port assertions for the low-voltage detect control block
`timescale 1ns/1ps
module lvd_checker (
  input wire aclk, aresetn, sleep_mode, global_irq_enable, comparator_low, s_axi_bvalid,
  input wire low_voltage_flag, low_voltage_irq_enable, irq_request, wake_request,
  input wire vector_on_wake, use_external_trip_input, detect_power_enable,
  input wire [3:0] trip_level_select,
  input wire [13:0] tap_select
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // request, wake and vector are gates of the sticky flag
  a_irq_gate: assert property (
    irq_request == (low_voltage_flag && low_voltage_irq_enable)) else $error("irq gate");
  a_wake_sleep: assert property (
    wake_request == (sleep_mode && irq_request)) else $error("wake gate");
  a_vector_gie: assert property (
    vector_on_wake == (wake_request && global_irq_enable)) else $error("vector gate");
  // flag only rises after the trip has passed both syncer stages
  a_flag_cause: assert property (
    $rose(low_voltage_flag) |-> $past(comparator_low, 3)) else $error("flag cause");
  a_flag_sticky: assert property (
    $fell(low_voltage_flag) |-> $rose(s_axi_bvalid)) else $error("flag dropped");
  a_ext_mux: assert property (
    $past(aresetn) |-> use_external_trip_input == ($past(trip_level_select) == 4'hF))
    else $error("ext mux");
  a_tap_map: assert property (
    $past(aresetn) && $past(trip_level_select) inside {[1:14]}
    |-> tap_select == 14'h0001 << ($past(trip_level_select) - 4'h1)) else $error("tap map");
  a_reset_state: assert property (
    $rose(aresetn) |-> trip_level_select == 4'h5 && !detect_power_enable && !low_voltage_flag)
    else $error("reset state");
  c_wake: cover property (wake_request);
  c_vector: cover property (vector_on_wake);
  c_clear: cover property ($fell(low_voltage_flag));
endmodule // lvd_checker
bind low_voltage_detect_ctrl lvd_checker u_chk (.*);

//--- sim/low_voltage_detect_ctrl_tb.sv
// self-checking bench for the low-voltage detect control block
`timescale 1ns/1ps
module low_voltage_detect_ctrl_tb;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, sleep_mode = 0, global_irq_enable = 0;
  logic ref_shared_on = 0, ext_low = 0;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'h1, supply = 4'hF;
  logic [31:0] s_axi_wdata = 0, last = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ref_settled;
  wire comparator_low, detect_power_enable, use_external_trip_input, low_voltage_flag;
  wire low_voltage_irq_enable, irq_request, wake_request, vector_on_wake;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0] trip_level_select;
  wire [13:0] tap_select;
  int failures = 0, checked = 0;
  // 25 MHz system clock
  always #20 aclk = ~aclk;
  low_voltage_detect_ctrl u_dut (.*);
  lvd_front_end u_front (.*);
  task automatic chk(string n, logic [33:0] e, logic [33:0] s);
    checked++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // each channel let go at the edge that takes it
  task automatic wr(logic [3:0] a, logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    fork
      begin @(posedge aclk iff s_axi_awready) s_axi_awvalid <= 1'h0; end
      begin @(posedge aclk iff s_axi_wready) s_axi_wvalid <= 1'h0; end
    join
    @(posedge aclk iff s_axi_bvalid) s_axi_bready <= 1'h0;
    chk("bresp", 0, s_axi_bresp);
    @(posedge aclk);
  endtask
  // an empty name only polls
  task automatic rd(string n, logic [3:0] a, logic [7:0] e, logic [1:0] er = 2'h0);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    @(posedge aclk iff s_axi_arready) s_axi_arvalid <= 1'h0;
    @(posedge aclk iff s_axi_rvalid) s_axi_rready <= 1'h0;
    last = s_axi_rdata;
    if (n != "") chk(n, {er, 24'h0, e}, {s_axi_rresp, s_axi_rdata});
    @(posedge aclk);
  endtask
  task automatic t_map;
    rd("ctrl reset", 4'h0, 8'h05);
    wr(4'h0, 8'hFF);
    rd("ctrl bits", 4'h0, 8'h1F);
    rd("unmapped", 4'h8, 8'h00, 2'h2);
    $display("map test done");
  endtask
  task automatic t_flag;
    wr(4'h0, 8'h00);
    supply <= 4'h0;
    wr(4'h0, 8'h13);
    rd("early flag", 4'h4, 8'h00);
    for (int i = 0; i < 20 && !last[5]; i++) rd("", 4'h0, 8'h00);
    chk("stable", 1, last[5]);
    rd("flag set", 4'h4, 8'h01);
    supply <= 4'hF;
    repeat (3) @(posedge aclk);
    rd("flag held", 4'h4, 8'h01);
    wr(4'h4, 8'h02);
    rd("flag clear", 4'h4, 8'h02);
    sleep_mode <= 1'h1;
    supply <= 4'h0;
    repeat (4) @(posedge aclk);
    #1 chk("wake", 2'h2, {wake_request, vector_on_wake});
    @(posedge aclk) global_irq_enable <= 1'h1;
    #1 chk("vector", 1, vector_on_wake);
    @(posedge aclk);
    $display("flag test done");
  endtask
  task automatic t_levels;
    supply <= 4'hF;
    for (int c = 1; c < 15; c++) begin
      wr(4'h0, 8'h10 | c);
      chk("tap", 34'h1 << (c - 1), tap_select);
    end
    wr(4'h0, 8'h1F);
    wr(4'h4, 8'h00);
    ext_low <= 1'h1;
    repeat (3) @(posedge aclk);
    rd("ext trip", 4'h4, 8'h01);
    ref_shared_on <= 1'h1;
    wr(4'h0, 8'h00);
    wr(4'h0, 8'h13);
    rd("shared ref", 4'h0, 8'h33);
    $display("levels test done");
  endtask
  task automatic finish_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_map();
    t_flag();
    t_levels();
    finish_test();
  end
  // watchdog far beyond the few hundred cycles needed
  initial begin
    #100us;
    failures++;
    finish_test();
  end
endmodule // low_voltage_detect_ctrl_tb
